// File: rtl/sar_pkg.sv
// shared constants and types for the sar readout link
package sar_pkg;
    localparam int CLK_NS = 4;
    localparam int DATA_W = 16;
    localparam int T_CONV_MIN_NS = 500;
    localparam int T_CONV_MAX_NS = 710;
    localparam int T_WH_CNV_NS = 10;
    localparam int T_SU_DIN_NS = 8;
    localparam int T_CYCLE_NS = 1000;
    localparam int SCLK_PERIOD_NS = 160;
    localparam int SCLK_SLOW_MAX_MHZ = 36;
    // least times round up, longest times round down
    localparam int CONV_MIN_CYC = (T_CONV_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int CONV_MAX_CYC = T_CONV_MAX_NS / CLK_NS;
    localparam int CONV_TYP_CYC = (CONV_MIN_CYC + CONV_MAX_CYC) / 2;
    localparam int WH_CYC = (T_WH_CNV_NS + CLK_NS - 1) / CLK_NS;
    localparam int SU_CYC = (T_SU_DIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYCLE_CYC = (T_CYCLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_NS);
    // synchroniser and edge-detect lag of the far end, with margin
    localparam int LINK_LAG_CYC = 4;
    localparam logic [4:0] FALLS_PLAIN = 5'h10;
    localparam logic [4:0] FALLS_BUSY = 5'h11;
    localparam logic [15:0] SAMPLE_RST = 16'h0000;
    typedef enum logic [3:0] {
        D_ACQ = 4'h1,
        D_CONV = 4'h2,
        D_HOLD = 4'h4,
        D_SHIFT = 4'h8
    } sar_dev_state_t;
    typedef enum logic [7:0] {
        H_IDLE = 8'h01,
        H_SETUP = 8'h02,
        H_CONV = 8'h04,
        H_WAITB = 8'h08,
        H_LEAD = 8'h10,
        H_HIGH = 8'h20,
        H_LOW = 8'h40,
        H_GAP = 8'h80
    } sar_host_state_t;
endpackage

// File: rtl/sar_link_if.sv
// four-wire link between converter and host
`timescale 1ns/1ps
`default_nettype none
interface sar_link_if;
    logic convert_select;
    logic sclk;
    logic din;
    logic dout_o;
    logic dout_oe;
    logic dout_line;
    // pull-up holds the line high while the converter floats it
    assign dout_line = dout_oe ? dout_o : 1'b1;
    modport dev (
        input convert_select,
        input sclk,
        input din,
        output dout_o,
        output dout_oe
    );
    modport host (
        output convert_select,
        output sclk,
        output din,
        input dout_line
    );
endinterface
`default_nettype wire

// File: rtl/sar_adc_dev.sv
// converter end: mode pick, timed conversion and serial readout
//
// Notes on behaviour
// R01 - din high at select rise: chip-select mode
// R02 - din low or tied: daisy-chain mode
// R03 - busy option puts one bit before data
// R04 - own clock converts; serial clock only shifts
// R05 - conversion length inside min-max window
// R06 - after conversion: powered down, result readable
// R07 - result is 16-bit unsigned straight binary
// R08 - select rise floats output, samples, converts
// R09 - conversion ignores select once started
// R10 - host returns select high before minimum time
// R11 - select high at end: no busy bit
// R12 - host lowers select only after maximum time
// R13 - select fall shows msb; falls shift rest
// R14 - host captures on falls at high rates
// R15 - host latches within hold after fall
// R16 - float after 16th fall or select rise
// R17 - busy host keeps select low through window
// R18 - select low at end: busy bit generated
// R19 - busy bit low, then msb-first on falls
// R20 - float after 17th fall or select rise
// R21 - result held until read or next conversion
`timescale 1ns/1ps
`default_nettype none
module sar_adc_dev #(
    parameter int CONV_CYC = sar_pkg::CONV_TYP_CYC
) (
    input wire logic REF_CLK,
    input wire logic RST,
    sar_link_if.dev LINK,
    input wire logic [15:0] SAMPLE_IN,
    output logic [15:0] RESULT,
    output logic RESULT_VALID,
    output logic POWER_DOWN,
    output logic DAISY_MODE,
    output logic BUSY_MODE
);
    // a length outside the window is pulled back into it
    localparam int CONV_LEN = (CONV_CYC < sar_pkg::CONV_MIN_CYC) ? sar_pkg::CONV_MIN_CYC :
        (CONV_CYC > sar_pkg::CONV_MAX_CYC) ? sar_pkg::CONV_MAX_CYC : CONV_CYC;
    localparam logic [15:0] CONV_LAST = 16'(CONV_LEN - 1);

    logic [2:0] cs_q;
    logic [2:0] ck_q;
    logic [2:0] di_q;
    logic cs_s;
    logic din_s;
    logic cs_rise;
    logic cs_fall;
    logic ck_fall;
    sar_pkg::sar_dev_state_t state_r;
    sar_pkg::sar_dev_state_t state_nxt;
    logic [15:0] conv_cnt_r;
    logic conv_done;
    logic in_conv;
    logic [15:0] sample_r;
    logic [15:0] sh_r;
    logic dout_r;
    logic oe_r;
    logic [4:0] fall_cnt_r;
    logic [4:0] fall_limit;
    logic last_fall;
    logic daisy_r;
    logic busy_r;

    // pins are asynchronous: two flops, then a third for edges
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            cs_q <= 3'h0;
            ck_q <= 3'h0;
            di_q <= 3'h0;
        end else begin
            cs_q <= {cs_q[1:0], LINK.convert_select};
            ck_q <= {ck_q[1:0], LINK.sclk};
            di_q <= {di_q[1:0], LINK.din};
        end
    end

    assign cs_s = cs_q[1];
    // din one stage later: its level just before the select edge
    assign din_s = di_q[2];
    assign cs_rise = cs_q[1] & ~cs_q[2];
    assign cs_fall = ~cs_q[1] & cs_q[2];
    assign ck_fall = ~ck_q[1] & ck_q[2];
    assign in_conv = (state_r == sar_pkg::D_CONV);
    assign conv_done = in_conv && (conv_cnt_r == CONV_LAST);
    assign fall_limit = busy_r ? sar_pkg::FALLS_BUSY : sar_pkg::FALLS_PLAIN;
    assign last_fall = !daisy_r && (fall_cnt_r == fall_limit - 5'h01);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            sar_pkg::D_ACQ: begin
                if (cs_rise) begin
                    state_nxt = sar_pkg::D_CONV; // see R08
                end
            end
            sar_pkg::D_CONV: begin
                // select edges are not looked at here
                if (conv_done) begin // see R09
                    if (daisy_r || !cs_s) begin
                        state_nxt = sar_pkg::D_SHIFT; // see R18
                    end else begin
                        state_nxt = sar_pkg::D_HOLD; // see R11
                    end
                end
            end
            sar_pkg::D_HOLD: begin
                if (cs_rise) begin
                    state_nxt = sar_pkg::D_CONV; // see R08
                end else if (cs_fall) begin
                    state_nxt = sar_pkg::D_SHIFT; // see R13
                end
            end
            sar_pkg::D_SHIFT: begin
                if (cs_rise) begin
                    state_nxt = sar_pkg::D_CONV; // see R16 R20
                end else if (ck_fall && last_fall) begin
                    state_nxt = sar_pkg::D_ACQ; // see R16 R20
                end
            end
            default: begin
                state_nxt = sar_pkg::D_ACQ;
            end
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            state_r <= sar_pkg::D_ACQ;
            POWER_DOWN <= 1'b1;
        end else begin
            state_r <= state_nxt;
            POWER_DOWN <= (state_nxt != sar_pkg::D_CONV); // see R06
        end
    end

    // conversion timed only by the local clock, never by sclk
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            conv_cnt_r <= 16'h0000;
        end else if (in_conv && !conv_done) begin
            conv_cnt_r <= conv_cnt_r + 16'h0001; // see R04 R05
        end else begin
            conv_cnt_r <= 16'h0000;
        end
    end

    // mode and sample caught at the select rise
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            sample_r <= sar_pkg::SAMPLE_RST;
            daisy_r <= 1'b0;
            DAISY_MODE <= 1'b0;
        end else if (cs_rise && !in_conv) begin
            sample_r <= SAMPLE_IN; // see R08
            daisy_r <= ~din_s; // see R01 R02
            DAISY_MODE <= ~din_s; // see R01 R02
        end
    end

    // busy decided by the select level at conversion end
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            busy_r <= 1'b0;
            BUSY_MODE <= 1'b0;
        end else if (conv_done) begin
            busy_r <= !daisy_r && !cs_s; // see R11 R18
            BUSY_MODE <= !daisy_r && !cs_s; // see R03
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            RESULT <= sar_pkg::SAMPLE_RST;
            RESULT_VALID <= 1'b0;
        end else begin
            RESULT_VALID <= conv_done;
            if (conv_done) begin
                RESULT <= sample_r; // see R07
            end
        end
    end

    // output shift path; bits change a few ref clocks after each sclk fall
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            sh_r <= sar_pkg::SAMPLE_RST;
            dout_r <= 1'b0;
            oe_r <= 1'b0;
            fall_cnt_r <= 5'h00;
        end else if (cs_rise && !in_conv) begin
            oe_r <= 1'b0; // see R08 R16 R20
            fall_cnt_r <= 5'h00;
        end else if (conv_done) begin
            fall_cnt_r <= 5'h00;
            if (daisy_r) begin
                // upstream shows its msb now, so din is caught in the same step
                oe_r <= 1'b1;
                dout_r <= sample_r[15];
                sh_r <= {sample_r[14:0], din_s};
            end else if (!cs_s) begin
                oe_r <= 1'b1; // see R19
                dout_r <= 1'b0; // see R03 R19
                sh_r <= sample_r; // see R21
            end else begin
                sh_r <= sample_r; // see R21
            end
        end else if (state_r == sar_pkg::D_HOLD && cs_fall) begin
            oe_r <= 1'b1; // see R13
            dout_r <= sh_r[15]; // see R13
            sh_r <= {sh_r[14:0], din_s};
        end else if (state_r == sar_pkg::D_SHIFT && ck_fall) begin
            fall_cnt_r <= fall_cnt_r + 5'h01;
            if (last_fall) begin
                oe_r <= 1'b0; // see R16 R20
            end else begin
                dout_r <= sh_r[15]; // see R13 R19
                sh_r <= {sh_r[14:0], din_s};
            end
        end
    end

    assign LINK.dout_o = dout_r;
    assign LINK.dout_oe = oe_r;
endmodule // sar_adc_dev
`default_nettype wire

// File: rtl/sar_adc_host.sv
// host end: drives select, sclk and din, reads back one result
`timescale 1ns/1ps
`default_nettype none
module sar_adc_host #(
    parameter int SCLK_HALF = sar_pkg::SCLK_HALF_CYC
) (
    input wire logic REF_CLK,
    input wire logic RST,
    sar_link_if.host LINK,
    input wire logic START,
    input wire logic USE_BUSY,
    input wire logic DAISY,
    output logic [15:0] DATA,
    output logic DATA_VALID,
    output logic READY
);
    localparam logic [15:0] HALF_LAST = 16'(SCLK_HALF - 1);
    localparam logic [15:0] WH_LAST = 16'(sar_pkg::WH_CYC - 1);
    localparam logic [15:0] SU_LAST = 16'(sar_pkg::SU_CYC - 1);
    localparam logic [15:0] WAIT_LAST = 16'(sar_pkg::CONV_MAX_CYC + sar_pkg::LINK_LAG_CYC - 1);
    localparam logic [15:0] CYC_LAST = 16'(sar_pkg::CYCLE_CYC - 1);
    localparam logic [15:0] LAG_LAST = 16'(sar_pkg::LINK_LAG_CYC);

    sar_pkg::sar_host_state_t state_r;
    logic [1:0] dl_q;
    logic dl_s;
    logic cs_r;
    logic ck_r;
    logic din_r;
    logic busy_r;
    logic daisy_r;
    logic [15:0] cnt_r;
    logic [15:0] cyc_r;
    logic [4:0] falls_r;
    logic [4:0] falls_last;
    logic [15:0] sh_r;
    logic half_done;
    logic cyc_ok;

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            dl_q <= 2'h3;
        end else begin
            dl_q <= {dl_q[0], LINK.dout_line};
        end
    end

    assign dl_s = dl_q[1];
    assign half_done = (cnt_r == HALF_LAST);
    assign cyc_ok = (cyc_r >= CYC_LAST);
    assign falls_last = (busy_r ? sar_pkg::FALLS_BUSY : sar_pkg::FALLS_PLAIN) - 5'h01;

    // spacing between conversions, counted from each select rise
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            cyc_r <= CYC_LAST;
        end else if (state_r == sar_pkg::H_SETUP && cnt_r == SU_LAST) begin
            cyc_r <= 16'h0000;
        end else if (!cyc_ok) begin
            cyc_r <= cyc_r + 16'h0001;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            state_r <= sar_pkg::H_IDLE;
            cs_r <= 1'b0;
            ck_r <= 1'b0;
            din_r <= 1'b1;
            busy_r <= 1'b0;
            daisy_r <= 1'b0;
            cnt_r <= 16'h0000;
            falls_r <= 5'h00;
            sh_r <= 16'h0000;
            DATA <= 16'h0000;
            DATA_VALID <= 1'b0;
            READY <= 1'b0;
        end else begin
            DATA_VALID <= 1'b0;
            cnt_r <= cnt_r + 16'h0001;
            READY <= (state_r == sar_pkg::H_IDLE) && cyc_ok && !START;
            case (state_r)
                sar_pkg::H_IDLE: begin
                    if (START && cyc_ok) begin
                        busy_r <= USE_BUSY & ~DAISY;
                        daisy_r <= DAISY;
                        din_r <= ~DAISY;
                        cnt_r <= 16'h0000;
                        state_r <= sar_pkg::H_SETUP;
                    end
                end
                sar_pkg::H_SETUP: begin
                    // din settles before the select edge that reads it
                    if (cnt_r == SU_LAST) begin
                        cs_r <= 1'b1;
                        cnt_r <= 16'h0000;
                        state_r <= sar_pkg::H_CONV;
                    end
                end
                sar_pkg::H_CONV: begin
                    if (busy_r && cnt_r == WH_LAST) begin
                        cs_r <= 1'b0; // see R17
                        cnt_r <= 16'h0000;
                        state_r <= sar_pkg::H_WAITB;
                    end else if (!busy_r && cnt_r == WAIT_LAST) begin
                        cs_r <= daisy_r; // see R10 R12
                        cnt_r <= 16'h0000;
                        state_r <= sar_pkg::H_LEAD;
                    end
                end
                sar_pkg::H_WAITB: begin
                    // the busy bit pulling the line low starts the read
                    // a daisy readout may still hold the line low until the converter floats it
                    if (!dl_s && cnt_r >= LAG_LAST) begin
                        cnt_r <= 16'h0000;
                        state_r <= sar_pkg::H_LEAD;
                    end
                end
                sar_pkg::H_LEAD, sar_pkg::H_LOW: begin
                    if (half_done) begin
                        ck_r <= 1'b1;
                        cnt_r <= 16'h0000;
                        state_r <= sar_pkg::H_HIGH;
                    end
                end
                sar_pkg::H_HIGH: begin
                    if (half_done) begin
                        // bit taken as the fall is made, inside its hold window
                        sh_r <= {sh_r[14:0], dl_s}; // see R14 R15
                        ck_r <= 1'b0;
                        cnt_r <= 16'h0000;
                        falls_r <= falls_r + 5'h01;
                        state_r <= sar_pkg::H_LOW;
                        if (falls_r == falls_last) begin
                            DATA <= {sh_r[14:0], dl_s};
                            DATA_VALID <= 1'b1;
                            falls_r <= 5'h00;
                            state_r <= sar_pkg::H_GAP;
                        end
                    end
                end
                sar_pkg::H_GAP: begin
                    cs_r <= 1'b0;
                    if (cyc_ok) begin
                        state_r <= sar_pkg::H_IDLE;
                    end
                end
                default: begin
                    state_r <= sar_pkg::H_IDLE;
                end
            endcase
        end
    end

    assign LINK.convert_select = cs_r;
    assign LINK.sclk = ck_r;
    assign LINK.din = din_r;
endmodule // sar_adc_host
`default_nettype wire

// File: test/sar_adc_sva.sv
// link assertions on the converter end's output
`timescale 1ns/1ps
`default_nettype none
module sar_adc_sva (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic convert_select,
    input wire logic sclk,
    input wire logic din,
    input wire logic dout_o,
    input wire logic dout_oe
);
    localparam int MINC = sar_pkg::CONV_MIN_CYC;
    localparam int MAXC = sar_pkg::CONV_MAX_CYC;
    logic sel_q_r;
    logic clk_q_r;
    logic nb_r;
    logic [9:0] cnt_r;
    logic [4:0] falls_r;
    logic [3:0] quiet_r;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);
    always_ff @(posedge REF_CLK) begin
        sel_q_r <= convert_select;
        clk_q_r <= sclk;
    end
    // saturates so checks tied to a count up to MAXC stay quiet once it is stale
    always_ff @(posedge REF_CLK) begin
        if (RST)
            cnt_r <= 10'h3ff;
        else if (convert_select && !sel_q_r)
            cnt_r <= 10'h000;
        else if (cnt_r != 10'h3ff)
            cnt_r <= cnt_r + 10'h001;
    end
    always_ff @(posedge REF_CLK) begin
        if (RST || (convert_select && !sel_q_r))
            falls_r <= 5'h00;
        else if (!sclk && clk_q_r && falls_r != 5'h1f)
            falls_r <= falls_r + 5'h01;
    end
    // select level near conversion end decides the busy bit
    always_ff @(posedge REF_CLK) begin
        if (RST)
            nb_r <= 1'b1;
        else if (cnt_r == 10'(MAXC))
            nb_r <= convert_select;
    end
    always_ff @(posedge REF_CLK) begin
        if (RST || (sclk != clk_q_r) || (convert_select != sel_q_r))
            quiet_r <= 4'h0;
        else if (quiet_r != 4'hf)
            quiet_r <= quiet_r + 4'h1;
    end
    sequence s_sel_rise;
        $rose(convert_select);
    endsequence
    sequence s_float;
        ##[0:4] !dout_oe;
    endsequence
    property p_rise_float;
        s_sel_rise |-> s_float;
    endproperty
    property p_conv_quiet;
        (cnt_r >= 10'h005 && cnt_r < 10'(MINC)) |-> !dout_oe;
    endproperty
    property p_cs_hold;
        (cnt_r == 10'(MAXC) && convert_select && din) |-> !dout_oe;
    endproperty
    property p_daisy;
        (cnt_r == 10'(MAXC) && convert_select && !din) |-> dout_oe;
    endproperty
    property p_busy_bit;
        (cnt_r == 10'(MAXC) && !convert_select && din) |-> dout_oe && !dout_o;
    endproperty
    property p_msb;
        ($fell(convert_select) && din && nb_r && cnt_r > 10'(MAXC)) |-> ##[1:5] dout_oe;
    endproperty
    property p_end16;
        ($fell(sclk) && falls_r == 5'h0f && nb_r && din) |-> ##[1:5] !dout_oe;
    endproperty
    property p_end17;
        ($fell(sclk) && falls_r == 5'h10 && !nb_r && din) |-> ##[1:5] !dout_oe;
    endproperty
    property p_stable;
        (quiet_r >= 4'h6 && dout_oe && $past(dout_oe)) |-> $stable(dout_o);
    endproperty
    a_rise_float: assert property (p_rise_float) else $error("output driven after select rise");
    a_conv_quiet: assert property (p_conv_quiet) else $error("output driven during conversion");
    a_cs_hold: assert property (p_cs_hold) else $error("output driven with select high");
    a_daisy: assert property (p_daisy) else $error("daisy output not driven");
    a_busy_bit: assert property (p_busy_bit) else $error("busy bit missing");
    a_msb: assert property (p_msb) else $error("no output after select fall");
    a_end16: assert property (p_end16) else $error("output held past sixteen falls");
    a_end17: assert property (p_end17) else $error("output held past seventeen falls");
    a_stable: assert property (p_stable) else $error("output moved without clock edge");
endmodule // sar_adc_sva
`default_nettype wire

// File: test/tb.sv
// self-checking bench for both link ends
`timescale 1ns/1ps
`default_nettype none
module tb;
    typedef struct packed {
        logic [15:0] sample;
        logic busy;
        logic daisy;
        logic exp_busy;
    } sar_row_t;
    localparam int TMO = 20000;
    sar_row_t rows [5] = '{'{16'h0000, 1'b0, 1'b0, 1'b0}, '{16'hffff, 1'b1, 1'b0, 1'b1},
                           '{16'ha5c3, 1'b0, 1'b1, 1'b0}, '{16'h8001, 1'b1, 1'b1, 1'b0},
                           '{16'h7ffe, 1'b1, 1'b0, 1'b1}};
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0;
    logic use_busy = 1'b0;
    logic daisy = 1'b0;
    int rv_cnt = 0;
    logic [15:0] sample_in = 16'h0000;
    logic [15:0] result;
    logic [15:0] data;
    logic result_valid;
    logic power_down;
    logic daisy_mode;
    logic busy_mode;
    logic data_valid;
    logic ready;
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;
    sar_link_if u_sar_link_if ();
    sar_adc_dev u_sar_adc_dev (.REF_CLK(ref_clk), .RST(rst), .LINK(u_sar_link_if), .SAMPLE_IN(sample_in),
        .RESULT(result), .RESULT_VALID(result_valid), .POWER_DOWN(power_down), .DAISY_MODE(daisy_mode),
        .BUSY_MODE(busy_mode));
    sar_adc_host u_sar_adc_host (.REF_CLK(ref_clk), .RST(rst), .LINK(u_sar_link_if), .START(start),
        .USE_BUSY(use_busy), .DAISY(daisy), .DATA(data), .DATA_VALID(data_valid), .READY(ready));
    sar_adc_sva u_sar_adc_sva (.REF_CLK(ref_clk), .RST(rst), .convert_select(u_sar_link_if.convert_select),
        .sclk(u_sar_link_if.sclk), .din(u_sar_link_if.din), .dout_o(u_sar_link_if.dout_o),
        .dout_oe(u_sar_link_if.dout_oe));
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (result_valid === 1'b1)
            rv_cnt <= rv_cnt + 1;
        if (cycles == TMO) begin
            end_sim();
        end
    end
    task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk1(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %s expected %b seen %b", what, exp, got);
        end
    endtask
    // one start pulse once the host is ready, every input set beside it
    task automatic go(input sar_row_t r);
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 4000) begin
            @(negedge ref_clk);
            n++;
        end
        sample_in = r.sample;
        use_busy = r.busy;
        daisy = r.daisy;
        start = 1'b1;
        @(negedge ref_clk);
        start = 1'b0;
    endtask
    // extra: refused start and a moving input while converting
    task automatic xfer(input sar_row_t r, input logic extra);
        int n;
        int base;
        base = rv_cnt;
        go(r);
        repeat (40) @(negedge ref_clk);
        chk1("power_down", 1'b0, power_down);
        chk1("ready", 1'b0, ready);
        if (extra) begin
            sample_in = ~r.sample;
            daisy = ~r.daisy;
            start = 1'b1;
            @(negedge ref_clk);
            start = 1'b0;
        end
        n = 0;
        while (data_valid !== 1'b1 && n < 3000) begin
            @(negedge ref_clk);
            n++;
        end
        chk1("data_valid", 1'b1, data_valid);
        chk16("data", r.sample, data);
        chk16("result", r.sample, result);
        chk16("result_valid", 16'h0001, 16'(rv_cnt - base));
        chk1("daisy_mode", r.daisy, daisy_mode);
        chk1("busy_mode", r.exp_busy, busy_mode);
        chk1("power_down", 1'b1, power_down);
    endtask
    task automatic end_sim();
        int late;
        // a run that hits the cycle ceiling counts as one mismatch
        late = (cycles >= TMO) ? 1 : 0;
        $display("comparisons %0d fails %0d", comparisons, fails + late);
        if (fails + late == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge ref_clk);
        rst = 1'b0;
        for (int i = 0; i < 5; i++) begin
            xfer(rows[i], 1'b0);
            $display("row %0d done", i);
        end
        xfer('{16'h3c5a, 1'b1, 1'b0, 1'b1}, 1'b1);
        $display("refused start done");
        // reset in mid conversion must leave the link floated
        go('{16'h1234, 1'b0, 1'b0, 1'b0});
        repeat (80) @(negedge ref_clk);
        chk1("power_down", 1'b0, power_down);
        rst = 1'b1;
        repeat (3) @(negedge ref_clk);
        rst = 1'b0;
        @(negedge ref_clk);
        chk1("power_down", 1'b1, power_down);
        chk1("dout_oe", 1'b0, u_sar_link_if.dout_oe);
        chk16("result", 16'h0000, result);
        xfer('{16'h0f0f, 1'b0, 1'b0, 1'b0}, 1'b0);
        $display("mid reset done");
        end_sim();
    end
endmodule // tb
`default_nettype wire
